// file: inc/pmf_pkg.sv
package pmf_pkg;

  // ----------------------------------------
  // Command codes of the management port
  // ----------------------------------------
  localparam logic [15:0] CMD_VIN = 16'h0088;
  localparam logic [15:0] CMD_IIN = 16'h0089;
  localparam logic [15:0] CMD_VOUT = 16'h008B;
  localparam logic [15:0] CMD_PIN = 16'h0097;
  localparam logic [15:0] CMD_WIN = 16'hFE3A;
  localparam logic [15:0] CMD_LAT1 = 16'hFE80;
  localparam logic [15:0] CMD_LAT2 = 16'hFE81;
  localparam logic [15:0] CMD_LAT3 = 16'hFE82;

  // ----------------------------------------
  // Reset values and limits
  // ----------------------------------------
  localparam logic [15:0] WIN_RST = 16'h0000;
  localparam logic [15:0] WIN_MAX = 16'h1000;
  localparam logic [7:0] FLAG_RST = 8'h00;
  localparam logic [15:0] RB_RST = 16'h0000;

  // ----------------------------------------
  // Metering arithmetic
  // ----------------------------------------
  localparam int SAMP_SHIFT = 6;
  localparam int ACC_W = 22 + SAMP_SHIFT;
  localparam int PWR_SHIFT = 5;
  localparam int PIN_W = 22 - PWR_SHIFT;
  localparam logic signed [4:0] VIN_EMIN = -5'sd3;
  localparam logic signed [4:0] VIN_EMAX = -5'sd1;
  localparam logic signed [4:0] IIN_EMIN = -5'sd10;
  localparam logic signed [4:0] IIN_EMAX = -5'sd5;
  localparam logic signed [4:0] PIN_EMIN = -5'sd4;
  localparam logic signed [4:0] PIN_EMAX = 5'sd3;
  localparam logic signed [4:0] VOUT_EMIN = -5'sd3;
  localparam logic signed [4:0] VOUT_EMAX = 5'sd0;

  // ----------------------------------------
  // Open-loop detection threshold
  // ----------------------------------------
  localparam int OLP_MV = 100;
  localparam int SENSE_LSB_UV = 1000;
  localparam logic [11:0] OLP_CNT = 12'(OLP_MV * 1000 / SENSE_LSB_UV);

  // ----------------------------------------
  // Condition inputs from the rest of the chip
  // ----------------------------------------
  typedef struct packed {
    logic max_mod;          // Upper modulation limit hit
    logic min_mod;          // Lower modulation limit hit
    logic quick_overvolt_trip; // Overvoltage comparator
    logic soft_start;       // Soft start running
    logic inrush_open;      // Inrush relay open
    logic nv_unlocked;      // Store unlocked
    logic nv_crc_bad;       // Store download bad
    logic addr_marginal;    // Address strap marginal
    logic quick_overcurrent_trip; // Current-limit comparator
    logic sync_locked;      // External sync locked
    logic fast_loop;        // Fast loop filter active
    logic core_rail_over;   // Core rail overvoltage
    logic io_rail_over;     // Supply rail overvoltage
    logic io_rail_under;    // Supply rail undervoltage
    logic vin_low;          // Early line-loss warning
    logic iin_warn;         // Input current warning
  } pmf_cond_s;

endpackage

// file: hw/pmf_meter_flags.sv
`timescale 1ns/1ps
// Operation
// - Half-cycle rms, 11 bits, internal only
// - Averaging window zero to 4096 cycles
// - Load averaged power at period end, hold
// - Readbacks in linear format, per-quantity exponent
// - Flags read 1 on fault; good flags low
// - Flag-driven pins are active high
// - Latched flag copies stick; read clears
// - Modulation limit flags bits 7 and 6
// - Open-loop flag on sense mismatch over 100 mV
// - Quick overvoltage and overcurrent trip flags
// - Missing period: use maximum, set flag
// - Below-start flag while line under threshold
// - Soft start flag during soft start
// - Inrush flag while relay open, drives pin
// - Store unlocked and store check flags
// - Address strap marginal flag
// - Line-level flag above high-line threshold
// - Line-good flag programmable combination, drives pin
// - Sync lock flag
// - Low power and fast loop flags
// - Rail over and under flags; undervoltage shutdown
module pmf_meter_flags
  import pmf_pkg::*;
(
  input wire logic clk_i,                 // Core clock
  input wire logic rst_i,                 // Async reset, high
  input wire logic [15:0] cmd_i,          // Command code
  input wire logic rd_i,                  // Read strobe
  input wire logic wr_i,                  // Write strobe
  input wire logic [15:0] wdata_i,        // Write data
  output logic [15:0] rdata_o,            // Read data
  input wire logic samp_vld_i,            // Sample valid
  input wire logic [10:0] vin_samp_i,     // Line voltage sample
  input wire logic [10:0] iin_samp_i,     // Line current sample
  input wire logic [10:0] vout_samp_i,    // Output voltage sample
  input wire logic half_end_i,            // Half line cycle ends
  input wire logic [11:0] feedback_sense_i, // Feedback sense code
  input wire logic [11:0] ovp_sense_i,    // Overvoltage sense code
  input wire logic period_det_i,          // Line period found
  input wire logic [15:0] period_meas_i,  // Measured period
  input wire logic [15:0] period_max_i,   // Programmed max period
  output logic [15:0] period_used_o,      // Period in use
  input wire logic [10:0] vin_on_i,       // Start-up threshold
  input wire logic [10:0] high_line_i,    // High-line threshold
  input wire logic [PIN_W-1:0] low_power_i, // Low power threshold
  input wire pmf_cond_s cond_i,           // Condition levels
  input wire logic [3:0] line_good_sel_i, // Line-good contributors
  input wire logic output_good_sel_i,     // Fast loop to output good
  input wire logic out_bad_i,             // Output not regulated
  input wire logic [6:0] resp_en_i,       // Shutdown responses
  output logic output_good_pin_o,         // Output good pin
  output logic line_good_pin_o,           // Line good pin
  output logic inrush_pin_o,              // Inrush relay drive
  output logic shutdown_o                 // Shutdown request
);

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------

  // Bit-serial integer square root
  function automatic logic [10:0] isqrt(input logic [21:0] x);
    logic [10:0] r;
    logic [10:0] t;
    r = '0;
    t = '0;
    for (int b = 10; b >= 0; b--) begin
      t = r | (11'h001 << b);
      if (22'(t) * 22'(t) <= x) begin
        r = t;
      end
    end
    return r;
  endfunction

  // Linear format: raise exponent until mantissa fits
  function automatic logic [15:0] lin_fmt(
    input logic [17:0] raw,
    input logic signed [4:0] emin,
    input logic signed [4:0] emax
  );
    logic [17:0] m;
    logic signed [4:0] e;
    m = raw;
    e = emin;
    for (int k = 0; k < 8; k++) begin
      if (m > 18'h003FF && e < emax) begin
        m = m >> 1;
        e = e + 5'sd1;
      end
    end
    if (m > 18'h003FF) begin
      m = 18'h003FF; // Saturate at top of range
    end
    return {e, m[10:0]};
  endfunction

  // ----------------------------------------
  // Half-cycle integration
  // ----------------------------------------
  logic [ACC_W-1:0] vsq_q; // Sum of voltage squares
  logic [ACC_W-1:0] isq_q; // Sum of current squares
  logic [ACC_W-1:0] pwr_q; // Sum of products
  logic [10:0] vout_q;     // Latest output sample

  // Accumulate samples, restart on half-cycle end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      vsq_q <= '0;
      isq_q <= '0;
      pwr_q <= '0;
    end else if (half_end_i) begin
      vsq_q <= '0;
      isq_q <= '0;
      pwr_q <= '0;
    end else if (samp_vld_i) begin
      vsq_q <= vsq_q + ACC_W'(vin_samp_i) * ACC_W'(vin_samp_i);
      isq_q <= isq_q + ACC_W'(iin_samp_i) * ACC_W'(iin_samp_i);
      pwr_q <= pwr_q + ACC_W'(vin_samp_i) * ACC_W'(iin_samp_i);
    end
  end

  // Keep last output voltage sample
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      vout_q <= '0;
    end else if (samp_vld_i) begin
      vout_q <= vout_samp_i;
    end
  end

  // ----------------------------------------
  // Half-cycle rms results, internal only
  // ----------------------------------------
  logic [10:0] vin_rms_q;      // Line voltage rms
  logic [10:0] iin_rms_q;      // Line current rms
  logic [PIN_W-1:0] pwr_hc_q;  // Half-cycle power
  logic hc_done_q;             // Results fresh

  // Close half cycle into rms figures
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      vin_rms_q <= '0;
      iin_rms_q <= '0;
      pwr_hc_q <= '0;
      hc_done_q <= 1'b0;
    end else begin
      hc_done_q <= half_end_i;
      if (half_end_i) begin
        vin_rms_q <= isqrt(vsq_q[ACC_W-1:SAMP_SHIFT]);
        iin_rms_q <= isqrt(isq_q[ACC_W-1:SAMP_SHIFT]);
        pwr_hc_q <= pwr_q[ACC_W-1:SAMP_SHIFT+PWR_SHIFT];
      end
    end
  end

  // ----------------------------------------
  // Averaging window
  // ----------------------------------------
  logic [15:0] win_q;      // Window length, full cycles
  logic [12:0] win_eff;    // Clamped window
  logic [13:0] tgt_hc;     // Half cycles per period
  logic [13:0] cnt_q;      // Half cycles so far
  logic [13:0] cnt_n;      // Count incl. this one
  logic avg_end;           // Period closes now
  logic [24:0] vs_q;       // Voltage rms sum
  logic [24:0] is_q;       // Current rms sum
  logic [30:0] ps_q;       // Power sum
  logic [24:0] vs_n;       // Voltage sum incl. this
  logic [24:0] is_n;       // Current sum incl. this
  logic [30:0] ps_n;       // Power sum incl. this

  // Window register write
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      win_q <= WIN_RST;
    end else if (wr_i && cmd_i == CMD_WIN) begin
      win_q <= wdata_i;
    end
  end

  // Period length; zero window closes each half cycle
  always_comb begin
    win_eff = (win_q > WIN_MAX) ? WIN_MAX[12:0] : win_q[12:0];
    tgt_hc = (win_eff == 13'h0000) ? 14'h0001 : {win_eff, 1'b0};
    cnt_n = cnt_q + 14'h0001;
    avg_end = hc_done_q && (cnt_n >= tgt_hc);
    vs_n = vs_q + 25'(vin_rms_q);
    is_n = is_q + 25'(iin_rms_q);
    ps_n = ps_q + 31'(pwr_hc_q);
  end

  // Sum half-cycle results over the period
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= '0;
      vs_q <= '0;
      is_q <= '0;
      ps_q <= '0;
    end else if (avg_end) begin
      cnt_q <= '0;
      vs_q <= '0;
      is_q <= '0;
      ps_q <= '0;
    end else if (hc_done_q) begin
      cnt_q <= cnt_n;
      vs_q <= vs_n;
      is_q <= is_n;
      ps_q <= ps_n;
    end
  end

  // ----------------------------------------
  // Readback registers
  // ----------------------------------------
  logic [15:0] vin_rb_q;   // Input voltage readback
  logic [15:0] iin_rb_q;   // Input current readback
  logic [15:0] vout_rb_q;  // Output voltage readback
  logic [15:0] pin_rb_q;   // Input power average

  // Load averages at period end only
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      vin_rb_q <= RB_RST;
      iin_rb_q <= RB_RST;
      pin_rb_q <= RB_RST;
    end else if (avg_end) begin
      vin_rb_q <= lin_fmt(18'(vs_n / cnt_n), VIN_EMIN, VIN_EMAX);
      iin_rb_q <= lin_fmt(18'(is_n / cnt_n), IIN_EMIN, IIN_EMAX);
      pin_rb_q <= lin_fmt(18'(ps_n / cnt_n), PIN_EMIN, PIN_EMAX);
    end
  end

  // Output voltage follows each half cycle
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      vout_rb_q <= RB_RST;
    end else if (hc_done_q) begin
      vout_rb_q <= lin_fmt(18'(vout_q), VOUT_EMIN, VOUT_EMAX);
    end
  end

  // ----------------------------------------
  // Line-derived flags, per half cycle
  // ----------------------------------------
  logic line_below_start_q; // Line under start level
  logic line_high_q;        // Line above high-line
  logic low_power_q;        // Power under low mode

  // Compare fresh rms against thresholds
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      line_below_start_q <= 1'b0;
      line_high_q <= 1'b0;
      low_power_q <= 1'b0;
    end else if (hc_done_q) begin
      line_below_start_q <= vin_rms_q < vin_on_i;
      line_high_q <= vin_rms_q > high_line_i;
      low_power_q <= pwr_hc_q < low_power_i;
    end
  end

  // ----------------------------------------
  // Live flag assembly
  // ----------------------------------------
  logic [11:0] sense_diff;  // Sense mismatch magnitude
  logic open_loop_detect;   // Dividers disagree
  logic line_period_missing; // No period found
  logic line_good_flag;     // Line not good, high
  logic out_good_bad;       // Output not good, high
  logic [7:0] live [3];     // Present flags

  // Build the three flag bytes, 1 means bad
  always_comb begin
    sense_diff = (feedback_sense_i > ovp_sense_i) ?
      feedback_sense_i - ovp_sense_i : ovp_sense_i - feedback_sense_i;
    open_loop_detect = sense_diff > OLP_CNT;
    line_period_missing = !period_det_i;
    line_good_flag = |(line_good_sel_i & {cond_i.vin_low,
      cond_i.iin_warn, cond_i.inrush_open, line_below_start_q});
    out_good_bad = out_bad_i
      | (output_good_sel_i & cond_i.fast_loop);
    live[0] = {cond_i.max_mod, cond_i.min_mod,
      open_loop_detect, cond_i.quick_overvolt_trip,
      line_period_missing, line_below_start_q,
      cond_i.soft_start, cond_i.inrush_open};
    live[1] = {1'b0, cond_i.nv_unlocked, cond_i.nv_crc_bad,
      cond_i.addr_marginal, line_high_q,
      cond_i.quick_overcurrent_trip, cond_i.sync_locked,
      line_good_flag};
    live[2] = {2'b00, low_power_q, cond_i.fast_loop,
      cond_i.core_rail_over, cond_i.io_rail_over,
      cond_i.io_rail_under, 1'b0};
  end

  // ----------------------------------------
  // Latched flag copies
  // ----------------------------------------
  logic [7:0] lat_q [3];    // Sticky flags
  logic [2:0] clr;          // Read clears register

  // Decode reads of the latched registers
  always_comb begin
    clr[0] = rd_i && cmd_i == CMD_LAT1;
    clr[1] = rd_i && cmd_i == CMD_LAT2;
    clr[2] = rd_i && cmd_i == CMD_LAT3;
  end

  // Sticky set; a new set survives the clearing read
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < 3; i++) begin
        lat_q[i] <= FLAG_RST;
      end
    end else begin
      for (int i = 0; i < 3; i++) begin
        lat_q[i] <= (clr[i] ? FLAG_RST : lat_q[i]) | live[i];
      end
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------

  // Answer one cycle after the read strobe, then hold
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= '0;
    end else if (rd_i) begin
      case (cmd_i)
        CMD_VIN: rdata_o <= vin_rb_q;
        CMD_IIN: rdata_o <= iin_rb_q;
        CMD_VOUT: rdata_o <= vout_rb_q;
        CMD_PIN: rdata_o <= pin_rb_q;
        CMD_WIN: rdata_o <= win_q;
        CMD_LAT1: rdata_o <= {8'h00, lat_q[0]};
        CMD_LAT2: rdata_o <= {8'h00, lat_q[1]};
        CMD_LAT3: rdata_o <= {8'h00, lat_q[2]};
        default: rdata_o <= '0; // Unknown code reads zero
      endcase
    end
  end

  // ----------------------------------------
  // Pins and responses
  // ----------------------------------------

  // Pins are active high, inverse of bad flags
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      output_good_pin_o <= 1'b0;
      line_good_pin_o <= 1'b0;
      inrush_pin_o <= 1'b0;
    end else begin
      output_good_pin_o <= !out_good_bad;
      line_good_pin_o <= !line_good_flag;
      inrush_pin_o <= !cond_i.inrush_open;
    end
  end

  // Shutdown: programmable responses plus forced one
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      shutdown_o <= 1'b0;
    end else begin
      shutdown_o <= cond_i.io_rail_under
        | |(resp_en_i & {open_loop_detect,
          cond_i.quick_overvolt_trip, cond_i.quick_overcurrent_trip,
          line_high_q, low_power_q,
          cond_i.core_rail_over, cond_i.io_rail_over});
    end
  end

  // Fall back to the maximum period when none is found
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      period_used_o <= '0;
    end else begin
      period_used_o <= period_det_i ? period_meas_i : period_max_i;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  lat_clear_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    clr[0] |=> lat_q[0] == $past(live[0]))
    else $error("latched byte not cleared to live flags");

  lat_sticky_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !clr[1] |=> (lat_q[1] & $past(lat_q[1])) == $past(lat_q[1]))
    else $error("latched flag dropped without read");

  pin_hold_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !avg_end |=> $stable(pin_rb_q))
    else $error("power readback changed mid period");

  win_zero_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (half_end_i && win_q == 16'h0000) |=> avg_end)
    else $error("zero window did not close period");

  pin_exp_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    avg_end |=> ($signed(pin_rb_q[15:11]) >= PIN_EMIN
      && $signed(pin_rb_q[15:11]) <= PIN_EMAX))
    else $error("power exponent out of range");

  brown_set_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    half_end_i ##1 (vin_rms_q < vin_on_i) |-> ##2 lat_q[0][2])
    else $error("below-start flag not latched");

  open_loop_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (sense_diff > OLP_CNT) |=> lat_q[0][5])
    else $error("open-loop flag not latched");

  io_under_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    cond_i.io_rail_under |=> shutdown_o && lat_q[2][1])
    else $error("undervoltage did not force shutdown");

  inrush_pin_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    cond_i.inrush_open ##1 cond_i.inrush_open |-> !inrush_pin_o)
    else $error("inrush pin asserted with relay flag set");

endmodule

// file: verif/pmf_host_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Host microcontroller on the management port
// ----------------------------------------
module pmf_host_model (
  input wire logic clk_i,          // Core clock
  input wire logic [15:0] rdata_i, // Read data
  output logic [15:0] cmd_o,       // Command code
  output logic rd_o,               // Read strobe
  output logic wr_o,               // Write strobe
  output logic [15:0] wdata_o      // Write data
);
  // Idle bus before the first request
  initial begin
    cmd_o = 16'h0000;
    rd_o = 1'b0;
    wr_o = 1'b0;
    wdata_o = 16'h0000;
  end

  // One-cycle read strobe; data taken after it lands and holds
  task automatic rd(input logic [15:0] cmd, output logic [15:0] data);
    @(posedge clk_i);
    cmd_o <= cmd;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    cmd_o <= ~cmd;
    @(negedge clk_i);
    data = rdata_i;
  endtask

  // One-cycle write strobe, code and data inverted afterwards
  task automatic wr(input logic [15:0] cmd, input logic [15:0] data);
    @(posedge clk_i);
    cmd_o <= cmd;
    wdata_o <= data;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
    cmd_o <= ~cmd;
    wdata_o <= ~data;
  endtask
endmodule

// file: verif/tb_power_metering_fault_flags.sv
`timescale 1ns/1ps
module tb_power_metering_fault_flags;
  import pmf_pkg::*;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic clk_i = 1'b0, rst_i = 1'b1, rd_i, wr_i, samp_vld = 1'b0;
  logic half_end = 1'b0, period_det = 1'b1, og_sel = 1'b0, out_bad = 1'b0;
  logic [15:0] cmd_i, wdata_i, rdata_o, period_used;
  logic [10:0] vs = 11'h000, is = 11'h000, vos = 11'h000;
  logic [10:0] vin_on = 11'h000, high_line = 11'h7FF;
  logic [11:0] fb = 12'h3E8, ovp = 12'h44C; // Differ by exactly 100
  logic [15:0] p_meas = 16'h1234, p_max = 16'h4321;
  logic [PIN_W-1:0] low_pwr = '0;
  pmf_cond_s cond = '0;
  logic [3:0] lg_sel = 4'h0;
  logic [6:0] resp_en = 7'h00;
  logic og_pin, lg_pin, inr_pin, shut;
  int error_cnt = 0, checks = 0;

  always #50 clk_i = ~clk_i; // 10 MHz

  pmf_host_model host (.clk_i(clk_i), .rdata_i(rdata_o), .cmd_o(cmd_i),
    .rd_o(rd_i), .wr_o(wr_i), .wdata_o(wdata_i));

  pmf_meter_flags dut (.clk_i(clk_i), .rst_i(rst_i), .cmd_i(cmd_i),
    .rd_i(rd_i), .wr_i(wr_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
    .samp_vld_i(samp_vld), .vin_samp_i(vs), .iin_samp_i(is),
    .vout_samp_i(vos), .half_end_i(half_end), .feedback_sense_i(fb),
    .ovp_sense_i(ovp), .period_det_i(period_det), .period_meas_i(p_meas),
    .period_max_i(p_max), .period_used_o(period_used), .vin_on_i(vin_on),
    .high_line_i(high_line), .low_power_i(low_pwr), .cond_i(cond),
    .line_good_sel_i(lg_sel), .output_good_sel_i(og_sel),
    .out_bad_i(out_bad), .resp_en_i(resp_en), .output_good_pin_o(og_pin),
    .line_good_pin_o(lg_pin), .inrush_pin_o(inr_pin), .shutdown_o(shut));

  // ----------------------------------------
  // Compare and helper tasks
  // ----------------------------------------
  task automatic chk16(string n, logic [15:0] e, logic [15:0] g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk1(string n, logic e, logic g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %b seen %b", n, e, g);
    end
  endtask

  // Read a register through the host and compare
  task automatic chk_rd(logic [15:0] c, logic [15:0] e);
    logic [15:0] d;
    host.rd(c, d);
    chk16($sformatf("reg %h", c), e, d);
  endtask

  // 64 samples, then the half-cycle close, then settle
  task automatic half(logic [10:0] v, logic [10:0] i, logic [10:0] vo);
    repeat (64) begin
      @(posedge clk_i);
      samp_vld <= 1'b1;
      vs <= v;
      is <= i;
      vos <= vo;
    end
    @(posedge clk_i);
    samp_vld <= 1'b0;
    half_end <= 1'b1;
    @(posedge clk_i);
    half_end <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask

  task automatic test_done();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Every register reads zero out of reset; window writable only
  task automatic t_regs();
    logic [15:0] codes [8] = '{CMD_VIN, CMD_IIN, CMD_VOUT, CMD_PIN,
      CMD_WIN, CMD_LAT1, CMD_LAT2, CMD_LAT3};
    foreach (codes[k]) chk_rd(codes[k], 16'h0000);
    host.wr(CMD_WIN, WIN_MAX);
    chk_rd(CMD_WIN, WIN_MAX);
    host.wr(CMD_VIN, 16'h1234);
    chk_rd(CMD_VIN, 16'h0000);
    host.wr(CMD_WIN, WIN_RST);
  endtask

  // One burst of every condition, then latched copies and clear
  task automatic t_flags();
    @(posedge clk_i);
    cond <= '1;
    lg_sel <= 4'h2;
    period_det <= 1'b0;
    ovp <= 12'h4B1;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    chk16("period", p_max, period_used);
    chk1("inrush", 1'b0, inr_pin);
    chk1("line good", 1'b0, lg_pin);
    chk1("shutdown", 1'b1, shut);
    @(posedge clk_i);
    cond <= '0;
    period_det <= 1'b1;
    ovp <= 12'h44C;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    chk16("period", p_meas, period_used);
    chk1("inrush", 1'b1, inr_pin);
    chk1("line good", 1'b1, lg_pin);
    chk1("shutdown", 1'b0, shut);
    chk_rd(CMD_LAT1, 16'h00FB);
    chk_rd(CMD_LAT2, 16'h0077);
    chk_rd(CMD_LAT3, 16'h001E);
    chk_rd(CMD_LAT1, 16'h0000);
    chk_rd(CMD_LAT2, 16'h0000);
    chk_rd(CMD_LAT3, 16'h0000);
  endtask

  // Output-good pin, enabled shutdown, set beating clear
  task automatic t_pins();
    @(posedge clk_i);
    out_bad <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk1("out good", 1'b0, og_pin);
    out_bad <= 1'b0;
    og_sel <= 1'b1;
    cond <= '{fast_loop: 1'b1, core_rail_over: 1'b1, default: 1'b0};
    repeat (2) @(posedge clk_i);
    chk1("out good", 1'b0, og_pin);
    chk1("shutdown", 1'b0, shut);
    og_sel <= 1'b0;
    resp_en <= 7'h02;
    repeat (2) @(posedge clk_i);
    chk1("out good", 1'b1, og_pin);
    chk1("shutdown", 1'b1, shut);
    resp_en <= 7'h00;
    cond <= '{max_mod: 1'b1, default: 1'b0};
    chk_rd(CMD_LAT3, 16'h0018);
    chk_rd(CMD_LAT1, 16'h0080);
    chk_rd(CMD_LAT1, 16'h0080);
    @(posedge clk_i);
    cond.max_mod <= 1'b0;
    chk_rd(CMD_LAT1, 16'h0080);
    chk_rd(CMD_LAT1, 16'h0000);
  endtask

  // Metering readbacks, threshold flags and window hold
  task automatic t_meter();
    @(posedge clk_i);
    vin_on <= 11'd900;
    high_line <= 11'd700;
    low_pwr <= 17'd20000;
    half(11'd800, 11'd400, 11'd1000);
    chk_rd(CMD_VIN, 16'hEB20);
    chk_rd(CMD_IIN, 16'hB190);
    chk_rd(CMD_VOUT, 16'hEBE8);
    chk_rd(CMD_PIN, 16'h0271);
    chk_rd(CMD_LAT1, 16'h0004);
    chk_rd(CMD_LAT2, 16'h0008);
    chk_rd(CMD_LAT3, 16'h0020);
    host.wr(CMD_WIN, 16'h0001);
    half(11'd400, 11'd400, 11'd1000);
    chk_rd(CMD_PIN, 16'h0271);
    half(11'd400, 11'd400, 11'd1000);
    chk_rd(CMD_PIN, 16'hFA71);
  endtask

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_flags();
    t_pins();
    t_meter();
    test_done();
  end

  initial begin
    repeat (5000) @(posedge clk_i);
    error_cnt++;
    test_done();
  end
endmodule
